/* File: ilcc_far_end.sv */
// Purpose: remote line end sending a repeating loopback code
// Assumes: one bit per clock on all four channels while sending
// Notes: phase restarts at each send; the detector has to slip into line with it
`timescale 1ns/1ps
module ilcc_far_end (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // code to send
   input wire logic send,
   input wire logic [7:0] code,
   input wire logic [3:0] code_len,
   // receive line toward the block
   output logic [3:0] rx_bit,
   output logic [3:0] rx_bit_valid
);
   logic [3:0] ph_ff, nxt_ph, bit_ff, nxt_bit, vld_ff, nxt_vld;
   always_comb begin
      nxt_ph = 4'h0;
      nxt_vld = 4'h0;
      // idle line flips so a stale level never looks like code
      nxt_bit = ~bit_ff;
      if (send) begin
         nxt_vld = 4'hF;
         nxt_bit = {4{code[3'd7 - ph_ff[2:0]]}};
         nxt_ph = (ph_ff + 4'h1 == code_len) ? 4'h0 : ph_ff + 4'h1;
      end
   end
   always_ff @(posedge clk) begin
      ph_ff <= srst ? 4'h0 : nxt_ph;
      vld_ff <= srst ? 4'h0 : nxt_vld;
      bit_ff <= srst ? 4'h0 : nxt_bit;
   end
   assign rx_bit = bit_ff;
   assign rx_bit_valid = vld_ff;
endmodule

/* File: ilcc_monitor.sv */
// Purpose: port checks for loopback code control
// Assumes: one clock, srst synchronous active high
// Notes: bound to ilcc_top
`timescale 1ns/1ps
module ilcc_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // line side
   input wire logic [3:0] rx_bit,
   input wire logic [3:0] rx_bit_valid,
   input wire logic [3:0] tx_bit_req,
   input wire logic [3:0] tx_pattern_bit,
   input wire logic [3:0] tx_pattern_on,
   input wire logic [3:0] remote_loop
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h08 || reg_addr > 8'h0F)
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   reserved_zero_a: assert property (reg_rd && reg_addr >= 8'h0B && reg_addr <= 8'h0F
      |=> reg_rdata[7:4] == 4'h0) else $error("reserved bits not zero");
   gen_off_a: assert property ((tx_pattern_bit & ~tx_pattern_on & ~$past(tx_pattern_on))
      == 4'h0) else $error("disabled generator drives a one");
   gen_hold_a: assert property (tx_bit_req == 4'h0 && tx_pattern_on == 4'hF
      ##1 tx_pattern_on == 4'hF |-> $stable(tx_pattern_bit)) else $error("bit moved unasked");
   irq_clear_a: assert property ((rx_bit_valid == 4'h0)[*3] ##0 (reg_rd && reg_addr == 8'h0B)
      ##2 (reg_rd && reg_addr == 8'h0D) |=> reg_rdata == 8'h00) else $error("irq not cleared");
   cfg_write_a: assert property (reg_wr && reg_addr == 8'h08 ##2 reg_rd && !reg_wr
      && reg_addr == 8'h08 |=> reg_rdata == ($past(reg_wdata, 3) & 8'h3F))
      else $error("config readback wrong");
   deact_write_a: assert property (reg_wr && reg_addr == 8'h0A ##2 reg_rd && !reg_wr
      && reg_addr == 8'h0A |=> reg_rdata == $past(reg_wdata, 3)) else $error("pattern readback wrong");
endmodule
bind ilcc_top ilcc_monitor mon_u (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
   .reg_rdata, .rx_bit, .rx_bit_valid, .tx_bit_req, .tx_pattern_bit, .tx_pattern_on, .remote_loop);

/* File: ilcc_pkg.sv */
// Purpose: constants for the inband loopback code control block
// Assumes: 8-bit expanded register space, four channels
// Notes: offsets are expanded addresses
package ilcc_pkg;
   localparam logic [7:0] ADDR_LOOP_CONFIG = 8'h08;
   localparam logic [7:0] ADDR_ACTIVATE_PATTERN = 8'h09;
   localparam logic [7:0] ADDR_DEACTIVATE_PATTERN = 8'h0A;
   localparam logic [7:0] ADDR_RX_LOOP_STATUS = 8'h0B;
   localparam logic [7:0] ADDR_LOOP_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_LOOP_IRQ_STATUS = 8'h0D;
   localparam logic [7:0] ADDR_GENERATOR_SELECT = 8'h0E;
   localparam logic [7:0] ADDR_GENERATOR_ENABLE = 8'h0F;
   localparam int CFG_DETECTOR_ENABLE_BIT = 5;
   localparam int CFG_AUTO_LOOP_ENABLE_BIT = 4;
   localparam int CFG_ACTIVATE_LENGTH_LSB = 2;
   localparam int CFG_DEACTIVATE_LENGTH_LSB = 0;
   localparam logic [5:0] CFG_WRITE_MASK = 6'h3F;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam int NUM_CHANNELS = 4;
   localparam int LENGTH_BASE = 5;
   // qualification time in microseconds and derived cycle count at 10 MHz
   localparam int QUALIFY_TIME_US = 5000;
   localparam int CLK_MHZ = 10;
   localparam int QUALIFY_CYCLES = QUALIFY_TIME_US * CLK_MHZ;
endpackage

/* File: ilcc_top.sv */
// Purpose: inband loopback code detection, status, masked events and generator control
// Assumes: one system clock, synchronous 8-bit register port, one bit per line clock strobe
// Notes: interrupt status bits are cleared by a read of the receive status register
//
// Function
// R1 - deactivate pattern is eight bits; length setting picks 8, 7, 6 or 5 top bits
// R2 - software replicates top bits of short patterns into unused low bits
// R3 - per-channel read-only status: 1 after activate detected, 0 after deactivate
// R4 - per-channel mask bit, reset to 0, must be 1 for an interrupt
// R5 - status change sets interrupt bit only when mask and detector enable are 1
// R6 - reading receive status clears interrupt status bits
// R7 - per-transmitter select: 0 activate generator, 1 deactivate generator
// R8 - per-transmitter enable turns the pattern generator on when 1
// R9 - software keeps upper four bits of per-channel registers at 0
// R10 - global detector enable turns pattern detection on when 1
// R11 - activate length field 00..11 selects 5..8 top bits of activate pattern
// R12 - auto loop enable lets detected patterns set or clear channel loopback
// R13 - detection needs a continuous match for the qualification interval
`timescale 1ns/1ps
module ilcc_top #(
   parameter int QUALIFY_CYCLES = ilcc_pkg::QUALIFY_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // receive line, one strobe per recovered bit
   input wire logic [3:0] rx_bit,
   input wire logic [3:0] rx_bit_valid,
   // transmit line, one strobe per transmitted bit
   input wire logic [3:0] tx_bit_req,
   output logic [3:0] tx_pattern_bit,
   output logic [3:0] tx_pattern_on,
   // loopback state per channel
   output logic [3:0] remote_loop
);
   localparam int CW = $clog2(QUALIFY_CYCLES + 1);

   logic [5:0] config_ff, nxt_config;
   logic [7:0] act_pat_ff, nxt_act_pat;
   logic [7:0] deact_pat_ff, nxt_deact_pat;
   logic [3:0] rx_loop_status_ff, nxt_rx_loop_status;
   logic [3:0] loop_irq_mask_ff, nxt_loop_irq_mask;
   logic [3:0] loop_irq_status_ff, nxt_loop_irq_status;
   logic [3:0] generator_select_ff, nxt_generator_select;
   logic [3:0] generator_enable_ff, nxt_generator_enable;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [3:0] remote_loop_ff, nxt_remote_loop;
   logic [3:0] act_hit, deact_hit;

   wire detector_enable = config_ff[ilcc_pkg::CFG_DETECTOR_ENABLE_BIT];
   wire auto_loop_enable = config_ff[ilcc_pkg::CFG_AUTO_LOOP_ENABLE_BIT];
   wire [1:0] activate_length = config_ff[ilcc_pkg::CFG_ACTIVATE_LENGTH_LSB +: 2];
   wire [1:0] deactivate_length = config_ff[ilcc_pkg::CFG_DEACTIVATE_LENGTH_LSB +: 2];
   // pattern period: length code 0..3 maps to 5..8 bits
   wire [3:0] act_len = 4'(ilcc_pkg::LENGTH_BASE) + {2'h0, activate_length}; // see R11
   wire [3:0] deact_len = 4'(ilcc_pkg::LENGTH_BASE) + {2'h0, deactivate_length}; // see R1

   // expected bit at phase p of a pattern of length n, taken from the top bits
   function automatic logic pat_bit(input logic [7:0] pat, input logic [2:0] p);
      pat_bit = pat[3'h7 - p];
   endfunction

   // per-channel detector and generator
   generate
      for (genvar ch = 0; ch < ilcc_pkg::NUM_CHANNELS; ch++) begin : g_ch
         logic [2:0] ap_ff, nxt_ap, dp_ff, nxt_dp, gp_ff, nxt_gp;
         logic [CW-1:0] ac_ff, nxt_ac, dc_ff, nxt_dc;
         logic gbit_ff, nxt_gbit;
         logic gon_ff, nxt_gon;
         // correlation against a running phase: a mismatch restarts the count and
         // holds the phase for one bit, so any rotation of the code lines up after slips
         always_comb begin
            nxt_ap = ap_ff;
            nxt_dp = dp_ff;
            nxt_ac = ac_ff;
            nxt_dc = dc_ff;
            if (!detector_enable) begin // see R10
               nxt_ac = '0;
               nxt_dc = '0;
            end else if (rx_bit_valid[ch]) begin
               if (rx_bit[ch] == pat_bit(act_pat_ff, ap_ff)) begin
                  if (ac_ff != CW'(QUALIFY_CYCLES)) nxt_ac = ac_ff + CW'(1); // see R13
                  nxt_ap = ({1'b0, ap_ff} + 4'h1 >= act_len) ? 3'h0 : ap_ff + 3'h1;
               end else begin
                  nxt_ac = '0;
               end
               if (rx_bit[ch] == pat_bit(deact_pat_ff, dp_ff)) begin
                  if (dc_ff != CW'(QUALIFY_CYCLES)) nxt_dc = dc_ff + CW'(1); // see R13
                  nxt_dp = ({1'b0, dp_ff} + 4'h1 >= deact_len) ? 3'h0 : dp_ff + 3'h1;
               end else begin
                  nxt_dc = '0;
               end
            end
         end
         // generator: bit presented when the transmitter asks for the next one
         always_comb begin
            nxt_gp = gp_ff;
            nxt_gbit = gbit_ff;
            nxt_gon = generator_enable_ff[ch]; // see R8
            if (!generator_enable_ff[ch]) begin
               nxt_gp = 3'h0;
               nxt_gbit = 1'b0;
            end else if (tx_bit_req[ch]) begin
               if (generator_select_ff[ch]) begin // see R7
                  nxt_gbit = pat_bit(deact_pat_ff, gp_ff);
                  nxt_gp = ({1'b0, gp_ff} + 4'h1 >= deact_len) ? 3'h0 : gp_ff + 3'h1;
               end else begin
                  nxt_gbit = pat_bit(act_pat_ff, gp_ff);
                  nxt_gp = ({1'b0, gp_ff} + 4'h1 >= act_len) ? 3'h0 : gp_ff + 3'h1;
               end
            end
         end
         always_ff @(posedge clk) begin
            if (srst) begin
               ap_ff <= 3'h0;
               dp_ff <= 3'h0;
               gp_ff <= 3'h0;
               ac_ff <= '0;
               dc_ff <= '0;
               gbit_ff <= 1'b0;
               gon_ff <= 1'b0;
            end else begin
               ap_ff <= nxt_ap;
               dp_ff <= nxt_dp;
               gp_ff <= nxt_gp;
               ac_ff <= nxt_ac;
               dc_ff <= nxt_dc;
               gbit_ff <= nxt_gbit;
               gon_ff <= nxt_gon;
            end
         end
         assign act_hit[ch] = (ac_ff == CW'(QUALIFY_CYCLES));
         assign deact_hit[ch] = (dc_ff == CW'(QUALIFY_CYCLES));
         assign tx_pattern_bit[ch] = gbit_ff;
         assign tx_pattern_on[ch] = gon_ff;
      end
   endgenerate

   // register file, status and events
   always_comb begin
      nxt_config = config_ff;
      nxt_act_pat = act_pat_ff;
      nxt_deact_pat = deact_pat_ff;
      nxt_loop_irq_mask = loop_irq_mask_ff;
      nxt_generator_select = generator_select_ff;
      nxt_generator_enable = generator_enable_ff;
      nxt_rx_loop_status = rx_loop_status_ff;
      nxt_loop_irq_status = loop_irq_status_ff;
      nxt_remote_loop = remote_loop_ff;
      nxt_rdata = rdata_ff;
      // upper bits are reserved and dropped on write, so they read back 0
      if (reg_wr) begin // see R9
         case (reg_addr)
            ilcc_pkg::ADDR_LOOP_CONFIG: nxt_config = reg_wdata[5:0] & ilcc_pkg::CFG_WRITE_MASK;
            ilcc_pkg::ADDR_ACTIVATE_PATTERN: nxt_act_pat = reg_wdata; // see R2
            ilcc_pkg::ADDR_DEACTIVATE_PATTERN: nxt_deact_pat = reg_wdata; // see R1
            ilcc_pkg::ADDR_LOOP_IRQ_MASK: nxt_loop_irq_mask = reg_wdata[3:0]; // see R4
            ilcc_pkg::ADDR_GENERATOR_SELECT: nxt_generator_select = reg_wdata[3:0];
            ilcc_pkg::ADDR_GENERATOR_ENABLE: nxt_generator_enable = reg_wdata[3:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            ilcc_pkg::ADDR_LOOP_CONFIG: nxt_rdata = {2'h0, config_ff};
            ilcc_pkg::ADDR_ACTIVATE_PATTERN: nxt_rdata = act_pat_ff;
            ilcc_pkg::ADDR_DEACTIVATE_PATTERN: nxt_rdata = deact_pat_ff;
            ilcc_pkg::ADDR_RX_LOOP_STATUS: nxt_rdata = {4'h0, rx_loop_status_ff};
            ilcc_pkg::ADDR_LOOP_IRQ_MASK: nxt_rdata = {4'h0, loop_irq_mask_ff};
            ilcc_pkg::ADDR_LOOP_IRQ_STATUS: nxt_rdata = {4'h0, loop_irq_status_ff};
            ilcc_pkg::ADDR_GENERATOR_SELECT: nxt_rdata = {4'h0, generator_select_ff};
            ilcc_pkg::ADDR_GENERATOR_ENABLE: nxt_rdata = {4'h0, generator_enable_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
      if (reg_rd && reg_addr == ilcc_pkg::ADDR_RX_LOOP_STATUS)
         nxt_loop_irq_status = 4'h0; // see R6
      for (int i = 0; i < ilcc_pkg::NUM_CHANNELS; i++) begin
         // activate wins if both qualify at once, which only a degenerate setup allows
         if (act_hit[i]) nxt_rx_loop_status[i] = 1'b1; // see R3
         else if (deact_hit[i]) nxt_rx_loop_status[i] = 1'b0; // see R3
         // set after the read-clear so a change in the read cycle is kept
         if (nxt_rx_loop_status[i] != rx_loop_status_ff[i] && loop_irq_mask_ff[i]
             && detector_enable)
            nxt_loop_irq_status[i] = 1'b1; // see R5
         if (auto_loop_enable && nxt_rx_loop_status[i] != rx_loop_status_ff[i])
            nxt_remote_loop[i] = nxt_rx_loop_status[i]; // see R12
         if (!auto_loop_enable)
            nxt_remote_loop[i] = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         config_ff <= 6'h00;
         act_pat_ff <= ilcc_pkg::RESET_VALUE;
         deact_pat_ff <= ilcc_pkg::RESET_VALUE;
         rx_loop_status_ff <= 4'h0;
         loop_irq_mask_ff <= 4'h0;
         loop_irq_status_ff <= 4'h0;
         generator_select_ff <= 4'h0;
         generator_enable_ff <= 4'h0;
         rdata_ff <= 8'h00;
         remote_loop_ff <= 4'h0;
      end else begin
         config_ff <= nxt_config;
         act_pat_ff <= nxt_act_pat;
         deact_pat_ff <= nxt_deact_pat;
         rx_loop_status_ff <= nxt_rx_loop_status;
         loop_irq_mask_ff <= nxt_loop_irq_mask;
         loop_irq_status_ff <= nxt_loop_irq_status;
         generator_select_ff <= nxt_generator_select;
         generator_enable_ff <= nxt_generator_enable;
         rdata_ff <= nxt_rdata;
         remote_loop_ff <= nxt_remote_loop;
      end
   end

   assign reg_rdata = rdata_ff;
   assign remote_loop = remote_loop_ff;
endmodule

/* File: inband_loopback_code_control_bench.sv */
// Purpose: self-checking bench for loopback code control
// Assumes: qualification shortened to 16 bits
// Notes: far end feeds all channels alike
`timescale 1ns/1ps
module inband_loopback_code_control_bench;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic send = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] code = 8'h00;
   logic [3:0] code_len = 4'h5;
   logic [3:0] tx_bit_req = 4'h0;
   logic [7:0] reg_rdata;
   logic [3:0] rx_bit, rx_bit_valid, tx_pattern_bit, tx_pattern_on, remote_loop;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   always #50 clk = ~clk;
   ilcc_top #(.QUALIFY_CYCLES(16)) dut_u (.clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .rx_bit, .rx_bit_valid, .tx_bit_req, .tx_pattern_bit, .tx_pattern_on, .remote_loop);
   ilcc_far_end far_u (.clk, .srst, .send, .code, .code_len, .rx_bit, .rx_bit_valid);
   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 cmp(reg_rdata, e);
   endtask
   // idle tail keeps reads clear of late status changes
   task automatic feed(input logic [7:0] c, input logic [3:0] n);
      code <= c;
      code_len <= n;
      send <= 1'b1;
      repeat (90) @(posedge clk);
      send <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task automatic txq(input logic [3:0] e);
      @(posedge clk);
      tx_bit_req <= 4'hF;
      @(posedge clk);
      tx_bit_req <= 4'h0;
      #1 cmp({4'h0, tx_pattern_bit}, {4'h0, e});
   endtask
   task automatic t_reset;
      for (logic [7:0] a = 8'h06; a < 8'h12; a++) chk(a, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_regs;
      logic [23:0] tbl [6] = '{24'h08FF3F, 24'h0AA9A9, 24'h0CFF0F, 24'h0BFF00, 24'h0E1A0A,
         24'h09C6C6};
      foreach (tbl[i]) begin
         wr(tbl[i][23:16], tbl[i][15:8]);
         chk(tbl[i][23:16], tbl[i][7:0]);
      end
      $display("register test done");
   endtask
   task automatic t_detect;
      wr(8'h0C, 8'h05);
      wr(8'h08, 8'h32);
      feed(8'hC6, 4'h5);
      cmp({4'h0, remote_loop}, 8'h0F);
      chk(8'h0D, 8'h05);
      chk(8'h0B, 8'h0F);
      chk(8'h0D, 8'h00);
      wr(8'h08, 8'h12);
      wr(8'h08, 8'h32);
      feed(8'hA9, 4'h7);
      cmp({4'h0, remote_loop}, 8'h00);
      chk(8'h0D, 8'h05);
      chk(8'h0B, 8'h00);
      wr(8'h08, 8'h12);
      feed(8'hC6, 4'h5);
      chk(8'h0D, 8'h00);
      chk(8'h0B, 8'h00);
      $display("detect test done");
   endtask
   task automatic t_gen;
      logic [7:0] ac = 8'hC6;
      logic [7:0] dc = 8'hA9;
      wr(8'h08, 8'h02);
      wr(8'h0E, 8'h0A);
      wr(8'h0F, 8'h0F);
      @(posedge clk);
      #1 cmp({4'h0, tx_pattern_on}, 8'h0F);
      // fifteen bits so the last one before disable is nonzero on the select-1 lanes
      for (int i = 0; i < 15; i++) begin
         txq({dc[7 - i % 7], ac[7 - i % 5], dc[7 - i % 7], ac[7 - i % 5]});
      end
      wr(8'h0F, 8'h00);
      txq(4'h0);
      cmp({4'h0, tx_pattern_on}, 8'h00);
      $display("generator test done");
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         stop_test;
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_reset;
      t_regs;
      t_detect;
      t_gen;
      stop_test;
   end
endmodule
